// ### verilog/fwc_defines.svh
// constants for the flash write control block
`ifndef FWC_DEFINES_SVH
`define FWC_DEFINES_SVH
`define FWC_BIT_WREN     0
`define FWC_BIT_ERSEL    1
`define FWC_BIT_BUSY     2
`define FWC_BIT_FAIL     3
`define FWC_BIT_VALID    4
`define FWC_TMR_LO       5
`define FWC_TMR_HI       6
`define FWC_BIT_DWORD    7
`define FWC_BANK_LO      8
`define FWC_BANK_HI      9
`define FWC_BIT_WMKEEP   15
`define FWC_PROT_RST     1'b1
`define FWC_PULSE_C0     128
`define FWC_PULSE_C1     2048
`define FWC_PULSE_C2     32768
`define FWC_PULSE_C3     262144
`define FWC_BANK0_LO     16'h0000
`define FWC_BANK0_HI     16'h2FFF
`define FWC_BANK1_LO     16'h3000
`define FWC_BANK1_HI     16'h5FFF
`define FWC_BANK2_LO     16'h6000
`define FWC_BANK2_HI     16'h77FF
`define FWC_BANK3_LO     16'h7800
`define FWC_BANK3_HI     16'h7FFF
`endif

// ### verilog/fwc_pkg.sv
// types for the flash write control block
package fwc_pkg;
  typedef enum logic [3:0] {
    OP_STANDARD  = 4'h1,
    OP_NONVERIFY = 4'h2,
    OP_PROGRAM   = 4'h4,
    OP_ERASE     = 4'h8
  } fwc_op_t;

  typedef enum logic [3:0] {
    RD_NORMAL_ANY = 4'h1,
    RD_NORMAL_IND = 4'h2,
    RD_PROG_VFY   = 4'h4,
    RD_ERASE_VFY  = 4'h8
  } fwc_rdmode_t;

  typedef enum logic [3:0] {
    ST_STD   = 4'h1,
    ST_ARMED = 4'h2,
    ST_WRITE = 4'h4,
    ST_BUSY  = 4'h8
  } fwc_state_t;

  // one cpu access into the active flash address space
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        direct;
    logic        word;
    logic        from_flash;
    logic [14:0] addr;
    logic [15:0] wdata;
  } fwc_acc_t;

  // request forwarded to the flash array
  typedef struct packed {
    logic        req;
    logic        we;
    logic [16:0] addr;
    logic [15:0] wdata;
  } fwc_arr_t;
endpackage

// ### verilog/fwc_mode_decode.sv
// decode of control bits into operation and read mode
`timescale 1ns/1ps
module fwc_mode_decode (
  input  wire logic            wm_keep,
  input  wire logic            erase_sel,
  input  wire logic            write_en,
  output fwc_pkg::fwc_op_t     op_mode,
  output fwc_pkg::fwc_rdmode_t rd_mode
);
  always_comb begin
    if (!wm_keep) begin
      op_mode = fwc_pkg::OP_STANDARD;
      rd_mode = fwc_pkg::RD_NORMAL_ANY;
    end else if (!write_en) begin
      op_mode = fwc_pkg::OP_NONVERIFY;
      rd_mode = fwc_pkg::RD_NORMAL_IND;
    end else if (erase_sel) begin
      op_mode = fwc_pkg::OP_ERASE;
      rd_mode = fwc_pkg::RD_ERASE_VFY;
    end else begin
      op_mode = fwc_pkg::OP_PROGRAM;
      rd_mode = fwc_pkg::RD_PROG_VFY;
    end
  end
endmodule

// ### verilog/fwc_pulse_timer.sv
// down counter that times one program or erase pulse
`timescale 1ns/1ps
module fwc_pulse_timer (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic [18:0] len,
  output logic             running,
  output logic             done
);
  logic [18:0] cnt_ff;
  logic        run_ff;
  logic        done_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      run_ff  <= 1'b0;
      cnt_ff  <= 19'h00000;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (start) begin
        run_ff <= 1'b1;
        cnt_ff <= len - 19'h00001;
      end else if (run_ff) begin
        if (cnt_ff == 19'h00000) begin
          run_ff  <= 1'b0;
          done_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff - 19'h00001;
        end
      end
    end
  end

  assign running = run_ff;
  assign done    = done_ff;
endmodule

// ### verilog/fwc_flash_write_control.sv
// flash write control: mode decode, virtual control register, pulses
`timescale 1ns/1ps
`include "fwc_defines.svh"
module fwc_flash_write_control #(
  parameter int PULSE_C0 = `FWC_PULSE_C0,
  parameter int PULSE_C1 = `FWC_PULSE_C1,
  parameter int PULSE_C2 = `FWC_PULSE_C2,
  parameter int PULSE_C3 = `FWC_PULSE_C3
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire fwc_pkg::fwc_acc_t acc,
  input  wire logic             vpp_ok,
  input  wire logic             protect_en,
  input  wire logic             map_high,
  output logic [15:0]           rdata_ff,
  output logic                  rvalid_ff,
  output fwc_pkg::fwc_arr_t     arr_ff,
  output fwc_pkg::fwc_rdmode_t  rd_mode_ff,
  output logic                  writing_mode_ff,
  output logic                  prog_pulse_ff,
  output logic                  erase_pulse_ff,
  output logic [16:0]           erase_lo_ff,
  output logic [16:0]           erase_hi_ff,
  output logic                  read_block_ff
);
  fwc_pkg::fwc_state_t  state_ff;
  fwc_pkg::fwc_state_t  nxt_state;
  fwc_pkg::fwc_op_t     op_mode;
  fwc_pkg::fwc_rdmode_t rd_mode;
  logic        wm_keep_ff;
  logic        write_en_ff;
  logic        erase_sel_ff;
  logic        dword_ff;
  logic        dword_half_ff;
  logic [1:0]  timer_sel_ff;
  logic [1:0]  bank_sel_ff;
  logic        prot_bit_ff;
  logic        valid_ff;
  logic        fail_ff;
  logic        busy_ff;
  logic [18:0] pulse_len;
  logic        tmr_run;
  logic        tmr_done;
  logic        in_write;
  logic        ctl_wr;
  logic        ind_wr;
  logic        start_prog;
  logic        start_erase;
  logic        start_op;
  logic        key_hit;
  logic [15:0] ctl_view;
  logic [15:0] lo_off;
  logic [15:0] hi_off;

  fwc_mode_decode u_decode (
    .wm_keep   (wm_keep_ff),
    .erase_sel (erase_sel_ff),
    .write_en  (write_en_ff),
    .op_mode   (op_mode),
    .rd_mode   (rd_mode)
  );

  always_comb begin
    case (timer_sel_ff)
      2'h0:    pulse_len = 19'(PULSE_C0);
      2'h1:    pulse_len = 19'(PULSE_C1);
      2'h2:    pulse_len = 19'(PULSE_C2);
      default: pulse_len = 19'(PULSE_C3);
    endcase
  end

  fwc_pulse_timer u_timer (
    .clk     (clk),
    .rst     (rst),
    .start   (start_op),
    .len     (pulse_len),
    .running (tmr_run),
    .done    (tmr_done)
  );

  // control register is only visible once the key sequence has run
  assign in_write = (state_ff == fwc_pkg::ST_WRITE) ||
                    (state_ff == fwc_pkg::ST_BUSY);
  assign ctl_wr   = in_write && acc.valid && acc.write && acc.direct &&
                    acc.word && !acc.addr[0];
  assign ind_wr   = in_write && acc.valid && acc.write && !acc.direct &&
                    !acc.addr[0] && !busy_ff;
  // key write: indirect, even, data equal to the address
  assign key_hit  = acc.valid && acc.write && !acc.direct &&
                    !acc.addr[0] && acc.wdata == {1'b0, acc.addr};
  // double-word programming waits for the second of two writes
  assign start_prog  = ind_wr && op_mode == fwc_pkg::OP_PROGRAM &&
                       (!dword_ff || dword_half_ff);
  assign start_erase = ind_wr && op_mode == fwc_pkg::OP_ERASE &&
                       acc.wdata == {1'b0, acc.addr};
  assign start_op    = start_prog || start_erase;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      fwc_pkg::ST_STD: begin
        if (acc.valid && acc.write && acc.direct && !acc.addr[0])
          nxt_state = fwc_pkg::ST_ARMED;
      end
      fwc_pkg::ST_ARMED: begin
        // any other access breaks the sequence
        if (acc.valid)
          nxt_state = key_hit ? fwc_pkg::ST_WRITE : fwc_pkg::ST_STD;
      end
      fwc_pkg::ST_WRITE: begin
        if (start_op)
          nxt_state = fwc_pkg::ST_BUSY;
        else if (ctl_wr && !acc.wdata[`FWC_BIT_WMKEEP])
          nxt_state = fwc_pkg::ST_STD;
      end
      fwc_pkg::ST_BUSY: begin
        if (tmr_done)
          nxt_state = fwc_pkg::ST_WRITE;
      end
      default: nxt_state = fwc_pkg::ST_STD;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst)
      state_ff <= fwc_pkg::ST_STD;
    else
      state_ff <= nxt_state;
  end

  // control fields; frozen while a pulse runs
  always_ff @(posedge clk) begin
    if (rst || nxt_state == fwc_pkg::ST_STD) begin
      wm_keep_ff   <= 1'b0;
      write_en_ff  <= 1'b0;
      erase_sel_ff <= 1'b0;
      dword_ff     <= 1'b0;
      timer_sel_ff <= 2'h0;
      bank_sel_ff  <= 2'h0;
    end else if (state_ff == fwc_pkg::ST_ARMED && key_hit) begin
      wm_keep_ff <= 1'b1;
    end else if (ctl_wr && !busy_ff) begin
      wm_keep_ff   <= acc.wdata[`FWC_BIT_WMKEEP];
      write_en_ff  <= acc.wdata[`FWC_BIT_WREN];
      erase_sel_ff <= acc.wdata[`FWC_BIT_ERSEL];
      dword_ff     <= acc.wdata[`FWC_BIT_DWORD];
      timer_sel_ff <= acc.wdata[`FWC_TMR_HI:`FWC_TMR_LO];
      bank_sel_ff  <= acc.wdata[`FWC_BANK_HI:`FWC_BANK_LO];
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !in_write || start_op)
      dword_half_ff <= 1'b0;
    else if (ind_wr && op_mode == fwc_pkg::OP_PROGRAM && dword_ff)
      dword_half_ff <= 1'b1;
  end

  always_ff @(posedge clk) begin
    if (rst)
      prot_bit_ff <= `FWC_PROT_RST;
    else if (ctl_wr && !busy_ff)
      prot_bit_ff <= acc.wdata[`FWC_BIT_BUSY];
    else if (state_ff == fwc_pkg::ST_STD && acc.valid && acc.write &&
             acc.direct && acc.word && acc.from_flash)
      prot_bit_ff <= acc.wdata[`FWC_BIT_BUSY];
  end

  always_ff @(posedge clk) begin
    if (rst)
      busy_ff <= 1'b0;
    else if (start_op)
      busy_ff <= 1'b1;
    else if (tmr_done)
      busy_ff <= 1'b0;
  end

  // sampled every cycle, reset included, so it tracks the pin
  always_ff @(posedge clk) begin
    valid_ff <= vpp_ok;
  end

  always_ff @(posedge clk) begin
    if (rst)
      fail_ff <= 1'b0;
    else if (start_op)
      fail_ff <= !vpp_ok;
    else if (busy_ff && !vpp_ok)
      fail_ff <= 1'b1;
  end

  // protection bit is written at the busy flag position, which reads back busy_ff
  assign ctl_view = {wm_keep_ff, 5'h00, bank_sel_ff, dword_ff,
                     timer_sel_ff, valid_ff, fail_ff, busy_ff,
                     erase_sel_ff, write_en_ff};

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff  <= 16'h0000;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= in_write && acc.valid && !acc.write && acc.direct;
      rdata_ff  <= ctl_view;
    end
  end

  // array path: indirect reads and program writes in writing mode, any read in standard mode
  always_ff @(posedge clk) begin
    if (rst) begin
      arr_ff <= '0;
    end else begin
      arr_ff.req <= acc.valid && !busy_ff &&
                    ((in_write && !acc.direct && (!acc.write ||
                      op_mode == fwc_pkg::OP_PROGRAM)) ||
                     (!in_write && !acc.write));
      arr_ff.we    <= in_write && acc.write && !acc.direct &&
                      op_mode == fwc_pkg::OP_PROGRAM;
      arr_ff.addr  <= {map_high, 1'b0, acc.addr};
      arr_ff.wdata <= acc.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_mode_ff      <= fwc_pkg::RD_NORMAL_ANY;
      writing_mode_ff <= 1'b0;
      prog_pulse_ff   <= 1'b0;
      erase_pulse_ff  <= 1'b0;
    end else begin
      rd_mode_ff      <= rd_mode;
      writing_mode_ff <= in_write;
      prog_pulse_ff   <= tmr_run && !erase_sel_ff;
      erase_pulse_ff  <= tmr_run && erase_sel_ff;
    end
  end

  always_comb begin
    case (bank_sel_ff)
      2'h0: begin
        lo_off = `FWC_BANK0_LO;
        hi_off = `FWC_BANK0_HI;
      end
      2'h1: begin
        lo_off = `FWC_BANK1_LO;
        hi_off = `FWC_BANK1_HI;
      end
      2'h2: begin
        lo_off = `FWC_BANK2_LO;
        hi_off = `FWC_BANK2_HI;
      end
      default: begin
        lo_off = `FWC_BANK3_LO;
        hi_off = `FWC_BANK3_HI;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      erase_lo_ff <= 17'h00000;
      erase_hi_ff <= 17'h00000;
    end else begin
      erase_lo_ff <= {map_high, lo_off};
      erase_hi_ff <= {map_high, hi_off};
    end
  end

  // blocks array reads issued from code outside the flash
  always_ff @(posedge clk) begin
    if (rst)
      read_block_ff <= 1'b0;
    else
      read_block_ff <= protect_en && prot_bit_ff && acc.valid &&
                       !acc.write && !acc.from_flash;
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic [18:0] busy_len_ff;
  logic [18:0] exp_len_ff;
  always_ff @(posedge clk) begin
    if (rst || start_op)
      busy_len_ff <= 19'h00000;
    else if (busy_ff)
      busy_len_ff <= busy_len_ff + 19'h00001;
  end
  always_ff @(posedge clk) begin
    if (start_op)
      exp_len_ff <= pulse_len;
  end

  sequence s_arm;
    state_ff == fwc_pkg::ST_STD && acc.valid && acc.write &&
      acc.direct && !acc.addr[0];
  endsequence
  sequence s_key;
    acc.valid && key_hit;
  endsequence

  a_unlock_enters: assert property (s_arm ##1 s_key |=> in_write)
    else $error("key sequence did not enter writing mode");
  a_write_only_key: assert property ($rose(in_write) |->
      $past(state_ff) == fwc_pkg::ST_ARMED)
    else $error("writing mode entered without key sequence");
  a_ctl_no_start: assert property (ctl_wr && !busy_ff |=> !busy_ff)
    else $error("control write started an operation");
  a_busy_set: assert property (start_op |=> busy_ff ##1 busy_ff)
    else $error("busy not held after command");
  a_pulse_length: assert property ($fell(busy_ff) |->
      busy_len_ff == exp_len_ff + 19'h00001)
    else $error("pulse length differs from timer code");
  a_fail_sticky: assert property (busy_ff && !vpp_ok && !start_op
      |=> fail_ff)
    else $error("supply drop not recorded");
  a_valid_mirror: assert property (##1 valid_ff == $past(vpp_ok))
    else $error("supply valid does not follow pin");
  a_ctl_read: assert property (in_write && acc.valid && !acc.write &&
      acc.direct |=> rvalid_ff && rdata_ff[2] == $past(busy_ff))
    else $error("control read not answered");
  a_prot_guard: assert property (state_ff == fwc_pkg::ST_STD &&
      acc.valid && !acc.from_flash |=> $stable(prot_bit_ff))
    else $error("protection changed from outside flash");
  a_erase_cmd: assert property (ind_wr &&
      op_mode == fwc_pkg::OP_ERASE &&
      acc.wdata != {1'b0, acc.addr} |=> !busy_ff)
    else $error("erase started without matching data");
endmodule

// ### verif/fwc_cpu_model.sv
// cpu model issuing accesses into the active flash address space
`timescale 1ns/1ps
module fwc_cpu_model (
  input  wire logic         clk,
  output fwc_pkg::fwc_acc_t acc
);
  initial acc = '0;
  // one access per call; back-to-back calls keep valid high
  task automatic put(input logic w, input logic d, input logic wd,
                     input logic ff, input logic [14:0] a,
                     input logic [15:0] wdat);
    @(posedge clk);
    acc <= {1'b1, w, d, wd, ff, a, wdat};
  endtask
  // a released bus shows the inverse of its last value, not stale data
  task automatic rest();
    @(posedge clk);
    acc <= {1'b0, ~acc[34:0]};
  endtask
  // key sequence must not be interrupted, so both accesses go back to back
  task automatic unlock(input logic [14:0] a);
    put(1'b1, 1'b1, 1'b1, 1'b0, a, {1'b0, a});
    put(1'b1, 1'b0, 1'b1, 1'b0, a, {1'b0, a});
    rest();
  endtask
  // control writes run from ram, always as whole words
  task automatic ctl(input logic [15:0] v);
    put(1'b1, 1'b1, 1'b1, 1'b0, 15'h0100, v);
    rest();
  endtask
  task automatic erase_cmd(input logic [14:0] a);
    put(1'b1, 1'b0, 1'b1, 1'b0, a, {1'b0, a});
    rest();
  endtask
endmodule

// ### verif/flash_write_control_tb.sv
// self-checking bench for the flash write control block
`timescale 1ns/1ps
module flash_write_control_tb;
  localparam int          LEN  [4] = '{4, 6, 8, 10};
  localparam logic [15:0] BLO  [4] = '{16'h0000, 16'h3000, 16'h6000, 16'h7800};
  localparam logic [15:0] BHI  [4] = '{16'h2FFF, 16'h5FFF, 16'h77FF, 16'h7FFF};
  localparam logic [15:0] CTLV [4] = '{16'h8003, 16'h8001, 16'h8000, 16'h8002};
  localparam logic [3:0]  RDM  [4] = '{4'h8, 4'h4, 4'h2, 4'h2};
  logic                 clk;
  logic                 rst;
  logic                 vpp_ok;
  logic                 protect_en;
  logic                 map_high;
  fwc_pkg::fwc_acc_t    acc;
  logic [15:0]          rdata_ff;
  logic                 rvalid_ff;
  fwc_pkg::fwc_arr_t    arr_ff;
  fwc_pkg::fwc_rdmode_t rd_mode_ff;
  logic                 writing_mode_ff;
  logic                 prog_pulse_ff;
  logic                 erase_pulse_ff;
  logic [16:0]          erase_lo_ff;
  logic [16:0]          erase_hi_ff;
  logic                 read_block_ff;
  logic [15:0]          v;
  logic                 ok;
  int                   n;
  int                   err_count = 0;
  int                   check_count = 0;
  always #2 clk = ~clk;
  fwc_cpu_model cpu (.clk(clk), .acc(acc));
  // short pulse lengths keep the run brief
  fwc_flash_write_control #(.PULSE_C0(4), .PULSE_C1(6), .PULSE_C2(8),
    .PULSE_C3(10)) DUT (.clk(clk), .rst(rst), .acc(acc), .vpp_ok(vpp_ok),
    .protect_en(protect_en), .map_high(map_high), .rdata_ff(rdata_ff),
    .rvalid_ff(rvalid_ff), .arr_ff(arr_ff), .rd_mode_ff(rd_mode_ff),
    .writing_mode_ff(writing_mode_ff), .prog_pulse_ff(prog_pulse_ff),
    .erase_pulse_ff(erase_pulse_ff), .erase_lo_ff(erase_lo_ff),
    .erase_hi_ff(erase_hi_ff), .read_block_ff(read_block_ff));
  task automatic close_out();
    if (err_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk_v(input logic [16:0] got, input logic [16:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd_ctl();
    cpu.put(1'b0, 1'b1, 1'b1, 1'b0, 15'h0100, 16'h0000);
    cpu.rest();
    #1;
    v = rdata_ff;
    ok = rvalid_ff;
  endtask
  task automatic blk_rd();
    cpu.put(1'b0, 1'b0, 1'b1, 1'b0, 15'h0200, 16'h0000);
    cpu.rest();
    #1;
    ok = read_block_ff;
  endtask
  task automatic count_pulse(input logic er, input logic drop);
    n = 0;
    for (int i = 0; i < 60; i++) begin
      @(posedge clk);
      vpp_ok <= !(drop && i == 1);
      #1;
      if ((er ? erase_pulse_ff : prog_pulse_ff) === 1'b1) n++;
    end
  endtask
  task automatic t_protect();
    blk_rd(); chk_b(ok, 1'b0);
    @(posedge clk) protect_en <= 1'b1;
    blk_rd(); chk_b(ok, 1'b1);
    cpu.put(1'b1, 1'b1, 1'b1, 1'b0, 15'h0100, 16'h0000);
    blk_rd(); chk_b(ok, 1'b1);
    cpu.put(1'b1, 1'b1, 1'b1, 1'b1, 15'h0100, 16'h0000);
    blk_rd(); chk_b(ok, 1'b0);
  endtask
  task automatic t_modes();
    cpu.unlock(15'h0100);
    repeat (2) @(posedge clk);
    #1 chk_b(writing_mode_ff, 1'b1);
    rd_ctl(); chk_b(ok, 1'b1);
    chk_v(17'(v & 16'h001C), 17'h00010);
    for (int i = 0; i < 4; i++) begin
      cpu.ctl(CTLV[i]);
      repeat (2) @(posedge clk);
      #1 chk_v(17'(rd_mode_ff), 17'(RDM[i]));
      chk_b(erase_pulse_ff | prog_pulse_ff, 1'b0);
    end
    @(posedge clk) vpp_ok <= 1'b0;
    rd_ctl(); chk_b(v[4], 1'b0);
    @(posedge clk) vpp_ok <= 1'b1;
  endtask
  task automatic t_erase();
    logic [1:0] b;
    for (int i = 0; i < 4; i++) begin
      b = 2'(i);
      @(posedge clk) map_high <= b[0];
      // chosen pulse widths stay within the stress limits at this clock
      cpu.ctl({1'b1, 5'h00, b, 1'b0, b, 5'h03});
      repeat (2) @(posedge clk);
      #1 chk_v(erase_lo_ff, {b[0], BLO[i]});
      chk_v(erase_hi_ff, {b[0], BHI[i]});
      if (i == 0) begin
        cpu.put(1'b1, 1'b0, 1'b1, 1'b0, 15'h0100, 16'h0102);
        cpu.rest();
        repeat (4) @(posedge clk);
        #1 chk_b(erase_pulse_ff, 1'b0);
        cpu.erase_cmd(15'h0100);
        rd_ctl(); chk_b(v[2], 1'b1);
        repeat (12) @(posedge clk);
      end else begin
        cpu.erase_cmd(15'h0100);
        count_pulse(1'b1, i == 2);
        chk_v(17'(n), 17'(LEN[i]));
      end
      rd_ctl(); chk_v(17'(v[3:2]), {15'h0000, i == 2, 1'b0});
      chk_v(17'(rd_mode_ff), 17'(fwc_pkg::RD_ERASE_VFY));
    end
  endtask
  task automatic t_program();
    cpu.ctl(16'h8001);
    cpu.put(1'b1, 1'b0, 1'b1, 1'b0, 15'h0202, 16'hA5A5);
    cpu.rest();
    #1 chk_b(arr_ff.req, 1'b1);
    chk_b(arr_ff.we, 1'b1);
    chk_v(arr_ff.addr, {map_high, 1'b0, 15'h0202});
    chk_v(17'(arr_ff.wdata), 17'h0A5A5);
    count_pulse(1'b0, 1'b0);
    chk_v(17'(n), 17'(LEN[0]));
    // double word: only the second of two writes may start the pulse
    cpu.ctl(16'h8081);
    cpu.put(1'b1, 1'b0, 1'b1, 1'b0, 15'h0204, 16'h1111);
    cpu.put(1'b1, 1'b0, 1'b1, 1'b0, 15'h0204, 16'h2222);
    cpu.rest();
    count_pulse(1'b0, 1'b0);
    chk_v(17'(n), 17'(LEN[0]));
    cpu.ctl(16'h0000);
    repeat (2) @(posedge clk);
    #1 chk_b(writing_mode_ff, 1'b0);
    chk_v(17'(rd_mode_ff), 17'(fwc_pkg::RD_NORMAL_ANY));
    rd_ctl(); chk_b(ok, 1'b0);
  endtask
  initial begin
    clk = 1'b0;
    rst <= 1'b1;
    vpp_ok <= 1'b1;
    protect_en <= 1'b0;
    map_high <= 1'b0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    #1 chk_v(17'(rd_mode_ff), 17'(fwc_pkg::RD_NORMAL_ANY));
    chk_b(writing_mode_ff, 1'b0);
    rd_ctl(); chk_b(ok, 1'b0);
    t_protect();
    t_modes();
    t_erase();
    t_program();
    close_out();
  end
  // the whole sequence needs well under two thousand cycles
  initial begin
    #20000;
    err_count++;
    close_out();
  end
endmodule
